// [rtl/uart_serial.sv]
`timescale 1ns/1ns
// How it works
// - Reset clears divider control register to zero.
// - Modulus field k divides by k plus 16.
// - Prescaler code picks source of clock over 2^(n-1).
// - Bit clock from prescaler or external pin.
// - Internal rate is clock over 2^n(k+16).
// - External rate is pin over 2(k+16).
// - Start, 7/8 data LSB first, parity, stops.
// - Seven-bit mode drops and zeroes bit 7.
// - Even parity sent gives even ones count.
// - Even parity received flags odd count.
// - Odd parity sent gives odd ones count.
// - Odd parity received flags even count.
// - Zero parity sends 0, never flags error.
// - No parity adds none, never flags error.
// - Settings reach 75 up to 38400 bps.
// - Internal select frees external clock pin.
// - Receiver checks only one stop bit.
// - Falling line starts counter, recheck at half.
module uart_serial #(
    parameter int TX_DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic txd,
    input wire logic rxd,
    input wire logic ext_baud_clk,
    output logic ext_pin_free,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);
    if (TX_DEPTH < 2) begin : g_bad_depth
        $error("TX_DEPTH must be at least 2.");
    end

    logic [1:0] rst_q;
    logic rst_n;
    uart_pkg::uart_state_t st_r;
    uart_pkg::uart_state_t st_nxt;

    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_take;
    logic [7:0] tx_word;
    logic [3:0] n_sel;
    logic [9:0] pre_mask;
    logic int_tick;
    logic ext_tick;
    logic src_tick;
    logic [4:0] mod_last;
    logic tx_half;
    logic tx_bit;
    logic rx_half;
    logic rx_bit;
    logic rxd_fall;
    logic [2:0] last_idx;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    sync_fifo #(
        .WIDTH(8),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    // Codes 1 to 4 and 15 are forbidden; they fall back to the slowest tap.
    assign n_sel = (st_r.baud_divider_control.tap >= uart_pkg::TAP_FASTEST && st_r.baud_divider_control.tap != 4'hf) ?
        st_r.baud_divider_control.tap - uart_pkg::TAP_OFFSET : uart_pkg::N_SLOWEST;
    assign pre_mask = uart_pkg::PRE_FULL >> (uart_pkg::N_SLOWEST - n_sel);
    assign int_tick = (st_r.pre & pre_mask) == pre_mask;
    assign ext_tick = st_r.ext_sync[1] == st_r.ext_sync[2] && st_r.ext_sync[2] && !st_r.ext_lvl;
    assign src_tick = st_r.mode.internal_clk ? int_tick : ext_tick;
    assign mod_last = {1'b0, st_r.baud_divider_control.modulus} + uart_pkg::MOD_LAST_BASE;
    // A counter past a freshly lowered limit wraps at once instead of running to 31.
    assign tx_half = src_tick && st_r.tx.cnt >= mod_last;
    assign tx_bit = tx_half && st_r.tx.half;
    assign rx_half = src_tick && st_r.rx.cnt >= mod_last;
    assign rx_bit = rx_half && st_r.rx.half;
    assign rxd_fall = st_r.rxd_sync[1] == st_r.rxd_sync[2] && !st_r.rxd_sync[2] && st_r.rxd_lvl;
    assign last_idx = st_r.mode.eight_bits ? uart_pkg::LAST_BIT8 : uart_pkg::LAST_BIT7;
    assign tx_word = st_r.mode.eight_bits ? fifo_data : {1'b0, fifo_data[6:0]};
    assign fifo_take = st_r.tx.st == uart_pkg::st_idle && st_r.mode.tx_en;

    always_comb begin
        st_nxt = st_r;
        // At 4 MHz the taps and moduli span about 63 to 125000 bps, so 75 and 38400 bps are reached.
        st_nxt.pre = st_r.pre + 10'h001;
        st_nxt.ext_sync = {st_r.ext_sync[1:0], ext_baud_clk};
        if (st_r.ext_sync[1] == st_r.ext_sync[2]) begin
            st_nxt.ext_lvl = st_r.ext_sync[2];
        end
        st_nxt.rxd_sync = {st_r.rxd_sync[1:0], rxd};
        if (st_r.rxd_sync[1] == st_r.rxd_sync[2]) begin
            st_nxt.rxd_lvl = st_r.rxd_sync[2];
        end

        if (bus_wr) begin
            if (bus_addr == uart_pkg::MODE_ADDR) begin
                st_nxt.mode = bus_wdata;
            end
            if (bus_addr == uart_pkg::BAUD_DIVIDER_CONTROL_ADDR) begin
                st_nxt.baud_divider_control = bus_wdata;
            end
        end
        if (bus_rd) begin
            unique case (bus_addr)
                uart_pkg::MODE_ADDR: st_nxt.rdata = st_r.mode;
                uart_pkg::STAT_ADDR: st_nxt.rdata = {5'h00, st_r.err};
                uart_pkg::BAUD_DIVIDER_CONTROL_ADDR: st_nxt.rdata = st_r.baud_divider_control;
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        if (src_tick) begin
            st_nxt.tx.cnt = tx_half ? 5'h00 : st_r.tx.cnt + 5'h01;
            st_nxt.rx.cnt = rx_half ? 5'h00 : st_r.rx.cnt + 5'h01;
        end
        if (tx_half) begin
            st_nxt.tx.half = !st_r.tx.half;
        end
        if (rx_half) begin
            st_nxt.rx.half = !st_r.rx.half;
        end

        if (!st_r.mode.tx_en) begin
            st_nxt.tx.st = uart_pkg::st_idle;
            st_nxt.txd = 1'b1;
        end else begin
            unique case (st_r.tx.st)
                uart_pkg::st_idle: begin
                    st_nxt.txd = 1'b1;
                    if (fifo_valid) begin
                        st_nxt.tx.st = uart_pkg::st_start;
                        st_nxt.tx.sh = tx_word;
                        st_nxt.tx.idx = 3'h0;
                        st_nxt.tx.cnt = 5'h00;
                        st_nxt.tx.half = 1'b0;
                        st_nxt.txd = 1'b0;
                        unique case (st_r.mode.parity)
                            uart_pkg::PAR_EVEN: st_nxt.tx.par = ^tx_word;
                            uart_pkg::PAR_ODD: st_nxt.tx.par = ~^tx_word;
                            default: st_nxt.tx.par = 1'b0;
                        endcase
                    end
                end
                uart_pkg::st_start: begin
                    if (tx_bit) begin
                        st_nxt.tx.st = uart_pkg::st_data;
                        st_nxt.txd = st_r.tx.sh[0];
                        st_nxt.tx.sh = st_r.tx.sh >> 1;
                    end
                end
                uart_pkg::st_data: begin
                    if (tx_bit) begin
                        if (st_r.tx.idx != last_idx) begin
                            st_nxt.tx.idx = st_r.tx.idx + 3'h1;
                            st_nxt.txd = st_r.tx.sh[0];
                            st_nxt.tx.sh = st_r.tx.sh >> 1;
                        end else if (st_r.mode.parity != uart_pkg::PAR_NONE) begin
                            st_nxt.tx.st = uart_pkg::st_parity;
                            st_nxt.txd = st_r.tx.par;
                        end else begin
                            st_nxt.tx.st = uart_pkg::st_stop;
                            st_nxt.txd = 1'b1;
                            st_nxt.tx.stop2 = st_r.mode.two_stops;
                        end
                    end
                end
                uart_pkg::st_parity: begin
                    if (tx_bit) begin
                        st_nxt.tx.st = uart_pkg::st_stop;
                        st_nxt.txd = 1'b1;
                        st_nxt.tx.stop2 = st_r.mode.two_stops;
                    end
                end
                uart_pkg::st_stop: begin
                    if (tx_bit) begin
                        if (st_r.tx.stop2) begin
                            st_nxt.tx.stop2 = 1'b0;
                        end else begin
                            st_nxt.tx.st = uart_pkg::st_idle;
                        end
                    end
                end
                default: st_nxt.tx.st = uart_pkg::st_idle;
            endcase
        end

        // Reading the byte clears the error flags; a new byte written below wins.
        if (rx_ready && st_r.rx_valid) begin
            st_nxt.rx_valid = 1'b0;
            st_nxt.err = '0;
        end

        if (!st_r.mode.rx_en) begin
            st_nxt.rx.st = uart_pkg::st_idle;
        end else begin
            unique case (st_r.rx.st)
                uart_pkg::st_idle: begin
                    if (rxd_fall) begin
                        st_nxt.rx.st = uart_pkg::st_start;
                        st_nxt.rx.cnt = 5'h00;
                        st_nxt.rx.half = 1'b0;
                    end
                end
                uart_pkg::st_start: begin
                    if (rx_half) begin
                        if (!st_r.rxd_lvl) begin
                            st_nxt.rx.st = uart_pkg::st_data;
                            st_nxt.rx.cnt = 5'h00;
                            st_nxt.rx.half = 1'b0;
                            st_nxt.rx.idx = 3'h0;
                            st_nxt.rx.par = 1'b0;
                        end else begin
                            st_nxt.rx.st = uart_pkg::st_idle;
                        end
                    end
                end
                uart_pkg::st_data: begin
                    if (rx_bit) begin
                        st_nxt.rx.sh = {st_r.rxd_lvl, st_r.rx.sh[7:1]};
                        st_nxt.rx.par = st_r.rx.par ^ st_r.rxd_lvl;
                        st_nxt.rx.idx = st_r.rx.idx + 3'h1;
                        if (st_r.rx.idx == last_idx) begin
                            st_nxt.rx.st = (st_r.mode.parity != uart_pkg::PAR_NONE) ?
                                uart_pkg::st_parity : uart_pkg::st_stop;
                        end
                    end
                end
                uart_pkg::st_parity: begin
                    if (rx_bit) begin
                        st_nxt.rx.par = st_r.rx.par ^ st_r.rxd_lvl;
                        st_nxt.rx.st = uart_pkg::st_stop;
                    end
                end
                uart_pkg::st_stop: begin
                    // One stop bit is checked whatever the transmit stop length.
                    if (rx_bit) begin
                        st_nxt.rx.st = uart_pkg::st_idle;
                        st_nxt.rx_data = st_r.mode.eight_bits ? st_r.rx.sh : {1'b0, st_r.rx.sh[7:1]};
                        st_nxt.rx_valid = 1'b1;
                        // A byte taken in this very cycle was read in time, so it is no overrun.
                        st_nxt.err.overrun = st_r.rx_valid && !rx_ready;
                        st_nxt.err.framing = !st_r.rxd_lvl;
                        unique case (st_r.mode.parity)
                            uart_pkg::PAR_EVEN: st_nxt.err.parity = st_r.rx.par;
                            uart_pkg::PAR_ODD: st_nxt.err.parity = !st_r.rx.par;
                            default: st_nxt.err.parity = 1'b0;
                        endcase
                    end
                end
                default: st_nxt.rx.st = uart_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.txd <= 1'b1;
            st_r.rxd_sync <= 3'h7;
            st_r.rxd_lvl <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata = st_r.rdata;
    assign txd = st_r.txd;
    assign ext_pin_free = st_r.mode.internal_clk;
    assign rx_data = st_r.rx_data;
    assign rx_valid = st_r.rx_valid;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_clears_baud_divider_control: assert property (
        !$past(rst_n) |-> st_r.baud_divider_control == uart_pkg::REG_RESET && st_r.mode == uart_pkg::REG_RESET)
        else $error("Divider control not zero after reset.");

    a_tap_fastest_rate: assert property (
        st_r.mode.internal_clk && st_r.baud_divider_control.tap == uart_pkg::TAP_FASTEST |-> src_tick)
        else $error("Fastest tap does not tick every clock.");

    a_tap_slowest_gap: assert property (
        st_r.mode.internal_clk && st_r.baud_divider_control.tap == uart_pkg::TAP_SLOWEST && src_tick
        ##1 $stable(st_r.baud_divider_control) |-> !src_tick [*8])
        else $error("Slowest tap ticks too often.");

    a_ext_source_only: assert property (
        !st_r.mode.internal_clk && !ext_tick |-> !src_tick)
        else $error("Source tick without external pin edge.");

    a_tx_start_low: assert property (
        st_r.tx.st == uart_pkg::st_start |-> !txd)
        else $error("Start bit not low.");

    a_tx_stop_high: assert property (
        st_r.tx.st == uart_pkg::st_stop || st_r.tx.st == uart_pkg::st_idle |-> txd)
        else $error("Stop or idle line not high.");

    a_rx_bit7_zero: assert property (
        $rose(rx_valid) && !st_r.mode.eight_bits |-> !rx_data[7])
        else $error("Seven-bit byte has bit 7 set.");

    a_parity_quiet: assert property (
        $rose(rx_valid) && !st_r.mode.parity[1] |-> !st_r.err.parity)
        else $error("Parity error without parity check.");

    a_start_recheck: assert property (
        st_r.mode.rx_en && st_r.rx.st == uart_pkg::st_start && rx_half && st_r.rxd_lvl
        |=> st_r.rx.st == uart_pkg::st_idle)
        else $error("High line at half bit accepted as start.");

    a_half_wrap: assert property (
        tx_half && st_r.tx.st != uart_pkg::st_idle |=> st_r.tx.cnt == 5'h00 && st_r.tx.half != $past(st_r.tx.half))
        else $error("Half-bit counter did not wrap and toggle.");

endmodule : uart_serial

// [rtl/uart_pkg.sv]
package uart_pkg;

    localparam logic [15:0] MODE_ADDR = 16'hff70;
    localparam logic [15:0] STAT_ADDR = 16'hff71;
    localparam logic [15:0] BAUD_DIVIDER_CONTROL_ADDR = 16'hff73;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [4:0] MOD_LAST_BASE = 5'h0f;
    localparam logic [3:0] TAP_SLOWEST = 4'h0;
    localparam logic [3:0] TAP_FASTEST = 4'h5;
    localparam logic [3:0] TAP_OFFSET = 4'h4;
    localparam logic [3:0] N_SLOWEST = 4'hb;
    localparam logic [9:0] PRE_FULL = 10'h3ff;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam logic [2:0] LAST_BIT7 = 3'h6;
    localparam logic [2:0] LAST_BIT8 = 3'h7;

    typedef enum logic [2:0] {st_idle, st_start, st_data, st_parity, st_stop} frame_state_t;

    typedef struct packed {
        logic [3:0] tap;
        logic [3:0] modulus;
    } baud_ctl_t;

    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic [1:0] parity;
        logic eight_bits;
        logic two_stops;
        logic err_int_mask;
        logic internal_clk;
    } mode_t;

    typedef struct packed {
        logic parity;
        logic framing;
        logic overrun;
    } rx_err_t;

    typedef struct packed {
        frame_state_t st;
        logic [4:0] cnt;
        logic half;
        logic [2:0] idx;
        logic [7:0] sh;
        logic par;
        logic stop2;
    } lane_t;

    typedef struct packed {
        baud_ctl_t baud_divider_control;
        mode_t mode;
        logic [9:0] pre;
        logic [2:0] ext_sync;
        logic ext_lvl;
        logic [2:0] rxd_sync;
        logic rxd_lvl;
        lane_t tx;
        lane_t rx;
        logic txd;
        logic [7:0] rx_data;
        logic rx_valid;
        rx_err_t err;
        logic [7:0] rdata;
    } uart_state_t;

endpackage : uart_pkg

// [rtl/sync_fifo.sv]
`timescale 1ns/1ns
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2.");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic in_rdy;
        logic out_vld;
    } fifo_state_t;

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid && st_r.in_rdy;
    assign pop = out_ready && st_r.out_vld;
    assign in_ready = st_r.in_rdy;
    assign out_valid = st_r.out_vld;
    assign out_data = mem[st_r.rp];

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        st_nxt.in_rdy = st_nxt.cnt != (AW+1)'(DEPTH);
        st_nxt.out_vld = st_nxt.cnt != '0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.in_rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The storage has no reset; only the pointers decide what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end

endmodule : sync_fifo

// [tb/remote_station.sv]
`timescale 1ns/1ns
module remote_station (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    int bit_clks = 32;

    initial rxd = 1'b1;

    task automatic put_bit(input logic b);
        @(posedge clk);
        #1 rxd = b;
        repeat (bit_clks - 1) @(posedge clk);
    endtask : put_bit

    // A stop level of 0 is a deliberate framing fault; the line is then returned to idle high.
    task automatic send_frame(input logic [7:0] d, input int nb, input bit has_par, input logic pbit,
                              input logic stop_lvl, input int nstop);
        put_bit(1'b0);
        for (int i = 0; i < nb; i++) begin
            put_bit(d[i]);
        end
        if (has_par) begin
            put_bit(pbit);
        end
        put_bit(stop_lvl);
        for (int i = 1; i < nstop; i++) begin
            put_bit(1'b1);
        end
        if (stop_lvl !== 1'b1) begin
            put_bit(1'b1);
        end
    endtask : send_frame

    task automatic glitch(input int n);
        @(posedge clk);
        #1 rxd = 1'b0;
        repeat (n) @(posedge clk);
        #1 rxd = 1'b1;
    endtask : glitch

    // Samples at bit centres, so a wrong bit period shows up as wrong bits.
    task automatic get_frame(output logic [7:0] d, output logic pbit, input int nb, input bit has_par,
                             input int nstop, output logic ok);
        d = 8'h00;
        pbit = 1'b0;
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge clk);
        ok = (txd === 1'b0);
        for (int i = 0; i < nb; i++) begin
            repeat (bit_clks) @(posedge clk);
            d[i] = txd;
        end
        if (has_par) begin
            repeat (bit_clks) @(posedge clk);
            pbit = txd;
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (bit_clks) @(posedge clk);
            ok = ok & (txd === 1'b1);
        end
    endtask : get_frame
endmodule : remote_station

// [tb/uart_baud_and_frame_format_tb.sv]
`timescale 1ns/1ns
module uart_baud_and_frame_format_tb;
    localparam logic [15:0] div_addr = 16'hff73;
    localparam int max_cycles = 60000;
    logic clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00, tx_data = 8'h00, bus_rdata, rx_data, v;
    logic tx_ready, txd, rxd, ext_pin_free, rx_valid, ext_run = 1'b0, ext_baud_clk = 1'b0;
    int n_errors = 0, n_tests = 0, cycles = 0, seed = 30601;
    logic [7:0] q [16];

    always #5 clk = ~clk;
    always begin
        #40;
        if (ext_run) ext_baud_clk = ~ext_baud_clk;
    end

    uart_serial dut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .txd(txd), .rxd(rxd), .ext_baud_clk(ext_baud_clk),
        .ext_pin_free(ext_pin_free), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
    remote_station peer (.clk(clk), .txd(txd), .rxd(rxd));

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == max_cycles) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_addr = a; bus_wdata = d; bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        bus_addr = a; bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0; d = bus_rdata;
    endtask : reg_read

    task automatic tx_push(input logic [7:0] d);
        @(negedge clk);
        tx_data = d; tx_valid = 1'b1;
        while (tx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask : tx_push

    function automatic logic par_bit(input logic [7:0] d, input int nb, input logic [1:0] pm);
        logic x;
        x = ^(nb == 8 ? d : d & 8'h7f);
        if (pm === uart_pkg::PAR_EVEN) return x;
        if (pm === uart_pkg::PAR_ODD) return ~x;
        return 1'b0;
    endfunction : par_bit

    function automatic logic [7:0] mode_byte(input logic tx, input logic [1:0] pm, input logic eb, input logic intl);
        return {tx, 1'b1, pm, eb, eb, 1'b0, intl};
    endfunction : mode_byte

    task automatic rx_expect(input logic [7:0] d, input logic [7:0] st);
        logic [7:0] s;
        int i;
        i = 0;
        while (rx_valid !== 1'b1 && i < 20000) begin
            @(negedge clk);
            i++;
        end
        reg_read(uart_pkg::STAT_ADDR, s);
        check("rx_status", s, st);
        check("rx_data", rx_data, d);
        @(negedge clk);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask : rx_expect

    // One frame out and one frame in with the current mode; the inbound parity may be spoiled.
    task automatic frame_pair(input logic [1:0] pm, input logic eb);
        logic [7:0] d, got, m;
        logic pb, ok, bad;
        int nb;
        nb = eb ? 8 : 7;
        m = eb ? 8'hff : 8'h7f;
        d = $random(seed);
        bad = $random(seed);
        fork
            tx_push(d);
            peer.get_frame(got, pb, nb, pm != uart_pkg::PAR_NONE, eb ? 2 : 1, ok);
        join
        check("tx_data", got, d & m);
        check("tx_frame", {7'h00, ok}, 8'h01);
        if (pm != uart_pkg::PAR_NONE) check("tx_parity", {7'h00, pb}, {7'h00, par_bit(d, nb, pm)});
        d = $random(seed);
        fork
            peer.send_frame(d, nb, pm != uart_pkg::PAR_NONE, par_bit(d, nb, pm) ^ bad, 1'b1, 1);
            rx_expect(d & m, {5'h00, bad & pm[1], 2'b00});
        join
    endtask : frame_pair

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        reg_read(div_addr, v);
        check("divider_reset", v, 8'h00);
        reg_read(16'hff7e, v);
        check("unmapped_read", v, 8'h00);
        // Slowest tap with the reset divider, so the long tick gap is watched.
        reg_write(uart_pkg::MODE_ADDR, 8'h01);
        repeat (2100) @(negedge clk);
        check("idle_line", {7'h00, txd}, 8'h01);
        reg_write(div_addr, 8'h50);
        for (int p = 0; p < 4; p++) begin
            for (int e = 0; e < 2; e++) begin
                reg_write(uart_pkg::MODE_ADDR, mode_byte(1'b1, p[1:0], e[0], 1'b1));
                frame_pair(p[1:0], e[0]);
            end
        end
        check("pin_free_internal", {7'h00, ext_pin_free}, 8'h01);
        // Tap code 6 gives n=2 and k=1 gives 17, so one bit is 2*2*17 clocks.
        reg_write(div_addr, 8'h61);
        reg_read(div_addr, v);
        check("divider_rw", v, 8'h61);
        peer.bit_clks = 68;
        frame_pair(uart_pkg::PAR_EVEN, 1'b1);
        // External pin: rising edge every 80 ns, 32 edges a bit.
        reg_write(div_addr, 8'h50);
        reg_write(uart_pkg::MODE_ADDR, mode_byte(1'b1, uart_pkg::PAR_ODD, 1'b1, 1'b0));
        repeat (3) @(negedge clk);
        check("pin_free_external", {7'h00, ext_pin_free}, 8'h00);
        ext_run = 1'b1;
        peer.bit_clks = 256;
        frame_pair(uart_pkg::PAR_ODD, 1'b1);
        ext_run = 1'b0;
        peer.bit_clks = 32;
        reg_write(uart_pkg::MODE_ADDR, mode_byte(1'b1, uart_pkg::PAR_NONE, 1'b1, 1'b1));
        peer.glitch(5);
        repeat (200) @(negedge clk);
        check("glitch_ignored", {7'h00, rx_valid}, 8'h00);
        q[0] = $random(seed);
        q[1] = $random(seed);
        fork
            begin
                peer.send_frame(q[0], 8, 1'b0, 1'b0, 1'b1, 1);
                peer.send_frame(q[1], 8, 1'b0, 1'b0, 1'b1, 1);
                peer.send_frame(8'h5a, 8, 1'b0, 1'b0, 1'b0, 1);
            end
            begin
                rx_expect(q[0], 8'h00);
                rx_expect(q[1], 8'h00);
                rx_expect(8'h5a, 8'h02);
            end
        join
        // Transmitter off, so the buffer fills until it refuses.
        reg_write(uart_pkg::MODE_ADDR, mode_byte(1'b0, uart_pkg::PAR_NONE, 1'b0, 1'b1));
        for (int i = 0; i < 16; i++) begin
            q[i] = $random(seed);
            tx_push(q[i]);
        end
        @(negedge clk);
        check("fifo_full", {7'h00, tx_ready}, 8'h00);
        fork
            reg_write(uart_pkg::MODE_ADDR, mode_byte(1'b1, uart_pkg::PAR_NONE, 1'b0, 1'b1));
            for (int i = 0; i < 16; i++) begin
                logic [7:0] g;
                logic pb, ok;
                peer.get_frame(g, pb, 7, 1'b0, 1, ok);
                check("fifo_drain", {ok, g[6:0]}, {1'b1, q[i][6:0]});
            end
        join
        repeat (40) @(negedge clk);
        check("fifo_empty", {7'h00, tx_ready}, 8'h01);
        print_verdict();
    end
endmodule : uart_baud_and_frame_format_tb
